// File: frs_pkg.sv
`default_nettype none
package frs_pkg;

    localparam int DATA_W  = 32;
    localparam int REF_W   = 16;
    localparam int ADDR_W  = 8;
    localparam int FUNC_W  = 8;
    localparam int NUM_DIN = 5;
    localparam int MEM_AW  = 5;
    localparam int MEM_WORDS = 18;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SCALE      = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_DINF_A     = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_DINF_B     = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_PULSE      = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_PRESET_BEG = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_PRESET_END = 8'h88;

    // Control register fields
    localparam int CTRL_SRC_LSB    = 0;
    localparam int CTRL_SRC_W      = 3;
    localparam int CTRL_SWAP_BIT   = 4;
    localparam int CTRL_AIN2F_LSB  = 8;
    localparam int CTRL_PULSEF_LSB = 16;
    localparam int CTRL_WIRE3_BIT  = 24;

    // Status register fields
    localparam int STAT_STEP_LSB  = 16;
    localparam int STAT_ALARM_BIT = 24;
    localparam int STAT_DIN_LSB   = 25;
    localparam int PULSE_REF_LSB  = 16;

    // Reset values
    localparam logic [CTRL_SRC_W-1:0] SRC_RST    = 3'h1;
    localparam logic [FUNC_W-1:0]     AIN2F_RST  = 8'h00;
    localparam logic [FUNC_W-1:0]     PULSEF_RST = 8'h00;
    localparam logic [REF_W-1:0]      SCALE_RST  = 16'h05A0;
    localparam logic [NUM_DIN*FUNC_W-1:0] DINF_RST = 40'h06_0403_050F;

    // Source selector and function codes
    localparam logic [CTRL_SRC_W-1:0] SRC_KEYPAD = 3'h0;
    localparam logic [CTRL_SRC_W-1:0] SRC_ANALOG = 3'h1;
    localparam logic [CTRL_SRC_W-1:0] SRC_PULSE  = 3'h4;
    localparam logic [FUNC_W-1:0] FN_MS1       = 8'h03;
    localparam logic [FUNC_W-1:0] FN_MS2       = 8'h04;
    localparam logic [FUNC_W-1:0] FN_MS3       = 8'h05;
    localparam logic [FUNC_W-1:0] FN_JOG       = 8'h06;
    localparam logic [FUNC_W-1:0] FN_MS4       = 8'h20;
    localparam logic [FUNC_W-1:0] FN_JOG2      = 8'h45;
    localparam logic [FUNC_W-1:0] AIN_FN_AUX   = 8'h02;
    localparam logic [FUNC_W-1:0] PULSE_FN_REF = 8'h00;

    // Memory slots beyond the sixteen presets, and the step number both jogs report
    localparam logic [MEM_AW-1:0] MEM_JOG  = 5'h10;
    localparam logic [MEM_AW-1:0] MEM_JOG2 = 5'h11;
    localparam logic [MEM_AW-1:0] STEP_JOG = 5'h11;

    // 100.00 % in units of 0.01 %
    localparam logic [REF_W-1:0] REF_FULL = 16'h2710;

    // Pulse gate timing
    localparam int CLK_HZ      = 10_000_000;
    localparam int GATE_MS     = 1000;
    localparam int GATE_CYCLES = CLK_HZ / 1000 * GATE_MS;
    localparam int DIV_STEPS   = 32;

endpackage
`default_nettype wire

// File: frs_ref_mem.sv
`timescale 1ns/1ps
`default_nettype none
module frs_ref_mem #(
    parameter int WORDS = 18,
    parameter int W     = 16,
    parameter int AW    = 5
) (
    input  wire logic          i_clk,
    input  wire logic          i_rst_n,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_waddr,
    input  wire logic [W-1:0]  i_wdata,
    input  wire logic [AW-1:0] i_raddr,
    output logic      [W-1:0]  o_rdata
);
    logic [W-1:0] mem [WORDS];
    logic [W-1:0] rdata_reg;

    // Array left unreset so it maps to plain RAM; presets read unknown until written
    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_reg <= '0;
        end else if (int'(i_raddr) < WORDS) begin
            rdata_reg <= mem[i_raddr];
        end else begin
            rdata_reg <= '0;
        end
    end

    assign o_rdata = rdata_reg;
endmodule
`default_nettype wire

// File: frs_pulse_meas.sv
`timescale 1ns/1ps
`default_nettype none
module frs_pulse_meas #(
    parameter int GATE_CYCLES = frs_pkg::GATE_CYCLES
) (
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    input  wire logic                     i_pulse_train_in,
    input  wire logic [frs_pkg::REF_W-1:0] i_scaling,
    output logic      [frs_pkg::REF_W-1:0] o_freq,
    output logic      [frs_pkg::REF_W-1:0] o_ref
);
    import frs_pkg::*;

    typedef struct packed {
        logic        s1;
        logic        s2;
        logic        s3;
        logic        lvl;
        logic [31:0] gate;
        logic [15:0] edges;
        logic [15:0] freq;
        logic        busy;
        logic [5:0]  bits;
        logic [31:0] num;
        logic [16:0] rem;
        logic [31:0] quo;
        logic [15:0] ref_v;
    } frs_pm_t;

    frs_pm_t st_reg;
    frs_pm_t st_next;
    logic [16:0] trial;
    logic        rise;

    always_comb begin
        st_next = st_reg;
        trial   = {st_reg.rem[15:0], st_reg.num[31]};
        rise    = 1'b0;
        st_next.s1 = i_pulse_train_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        if (st_reg.s2 == st_reg.s3) begin
            st_next.lvl = st_reg.s3;
            rise        = st_reg.s3 && !st_reg.lvl;
            if (rise && (st_reg.edges != '1)) begin
                st_next.edges = st_reg.edges + 16'h0001;
            end
        end
        if (st_reg.gate >= 32'(GATE_CYCLES - 1)) begin
            // Edges per one-second gate equal the frequency in Hz
            st_next.gate  = '0;
            // An edge seen on the closing cycle opens the next count, so none is lost
            st_next.edges = {15'h0000, rise};
            st_next.freq  = st_reg.edges;
            st_next.num   = 32'(st_reg.edges) * 32'(REF_FULL);
            st_next.rem   = '0;
            st_next.quo   = '0;
            st_next.bits  = 6'(DIV_STEPS);
            st_next.busy  = 1'b1;
        end else begin
            st_next.gate = st_reg.gate + 32'h0000_0001;
        end
        // Scaling frequency maps to 100 %; zero scaling saturates
        if (st_reg.busy) begin
            st_next.num = {st_reg.num[30:0], 1'b0};
            if (trial >= {1'b0, i_scaling}) begin
                st_next.rem = trial - {1'b0, i_scaling};
                st_next.quo = {st_reg.quo[30:0], 1'b1};
            end else begin
                st_next.rem = trial;
                st_next.quo = {st_reg.quo[30:0], 1'b0};
            end
            st_next.bits = st_reg.bits - 6'h01;
            if (st_reg.bits == 6'h01) begin
                st_next.busy  = 1'b0;
                st_next.ref_v = (st_next.quo[31:16] != '0) ? '1 : st_next.quo[15:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_freq = st_reg.freq;
    assign o_ref  = st_reg.ref_v;
endmodule
`default_nettype wire

// File: frs_ref_select.sv
`timescale 1ns/1ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////////////////
module frs_ref_select #(
    parameter int GATE_CYCLES = frs_pkg::GATE_CYCLES
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_psel,
    input  wire logic                          i_penable,
    input  wire logic                          i_pwrite,
    input  wire logic [frs_pkg::ADDR_W-1:0]    i_paddr,
    input  wire logic [frs_pkg::DATA_W-1:0]    i_pwdata,
    output logic      [frs_pkg::DATA_W-1:0]    o_prdata,
    output logic                               o_pready,
    output logic                               o_pslverr,
    input  wire logic [frs_pkg::NUM_DIN-1:0]   i_din,
    input  wire logic [frs_pkg::REF_W-1:0]     i_analog_in_first,
    input  wire logic [frs_pkg::REF_W-1:0]     i_analog_in_second,
    input  wire logic                          i_pulse_train_in,
    output logic      [frs_pkg::REF_W-1:0]     o_freq_ref,
    output logic      [frs_pkg::MEM_AW-1:0]    o_ref_step,
    output logic                               o_param_setting_alarm
);
    import frs_pkg::*;

    typedef struct packed {
        logic [CTRL_SRC_W-1:0]       src;
        logic                        swap;
        logic [FUNC_W-1:0]           ain2f;
        logic [FUNC_W-1:0]           pulsef;
        logic                        wire3;
        logic [REF_W-1:0]            scale;
        logic [NUM_DIN*FUNC_W-1:0]   dinf;
        logic [NUM_DIN-1:0]          s1;
        logic [NUM_DIN-1:0]          s2;
        logic [NUM_DIN-1:0]          s3;
        logic [NUM_DIN-1:0]          din;
        logic                        pready;
        logic                        pslverr;
        logic [DATA_W-1:0]           prdata;
        logic                        mem_wait;
        logic                        sel_valid;
        logic                        use_mem;
        logic [REF_W-1:0]            value;
        logic [MEM_AW-1:0]           step_p;
        logic [REF_W-1:0]            fref;
        logic [MEM_AW-1:0]           step;
        logic                        alarm;
    } frs_state_t;

    frs_state_t st_reg;
    frs_state_t st_next;

    logic [REF_W-1:0]  mem_rdata;
    logic [REF_W-1:0]  pulse_freq;
    logic [REF_W-1:0]  pulse_ref;
    logic              mem_we;
    logic [MEM_AW-1:0] mem_raddr;
    logic [MEM_AW-1:0] apb_idx;
    logic [ADDR_W-1:0] apb_ofs;
    logic              apb_acc;
    logic              in_mem;
    logic              apb_steal;
    logic              ms1;
    logic              ms2;
    logic              ms3;
    logic              ms4;
    logic              jog;
    logic              jog2;
    logic              jog2_assigned;
    logic              aux_en;
    logic [REF_W-1:0]  master_ain;
    logic [REF_W-1:0]  aux_ain;
    logic [MEM_AW-1:0] sel_idx;
    logic [DATA_W-1:0] rd_mux;
    logic              mapped;

    //////////////////////////////////////////////////////////////////////////////////////////
    // Terminals sharing a code are ORed, so a duplicate never masks another
    // True when any terminal assigned to the code is on
    function automatic logic din_active(input logic [NUM_DIN*FUNC_W-1:0] f,
                                        input logic [NUM_DIN-1:0]        lv,
                                        input logic [FUNC_W-1:0]         code);
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < NUM_DIN; k++) begin
            if (f[k*FUNC_W +: FUNC_W] == code) begin
                hit = hit | lv[k];
            end
        end
        return hit;
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////////
    // Function decode of filtered terminals; levels are sampled live
    always_comb begin
        ms1  = din_active(st_reg.dinf, st_reg.din, FN_MS1);
        ms2  = din_active(st_reg.dinf, st_reg.din, FN_MS2);
        ms3  = din_active(st_reg.dinf, st_reg.din, FN_MS3);
        jog  = din_active(st_reg.dinf, st_reg.din, FN_JOG);
        ms4  = din_active(st_reg.dinf, st_reg.din, FN_MS4);
        jog2 = din_active(st_reg.dinf, st_reg.din, FN_JOG2) & st_reg.wire3;
        jog2_assigned = din_active(st_reg.dinf, '1, FN_JOG2);
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Analog routing
    // Words arrive on this clock already, so they bypass the terminal filter
    always_comb begin
        if (st_reg.swap) begin
            // Second input becomes master, first input takes the selected function
            master_ain = i_analog_in_second;
            aux_ain    = i_analog_in_first;
        end else begin
            master_ain = i_analog_in_first;
            aux_ain    = i_analog_in_second;
        end
        aux_en = (st_reg.ain2f == AIN_FN_AUX);
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // APB decode
    // Preset reads borrow the RAM port; the reference pipeline pauses meanwhile
    always_comb begin
        apb_acc   = i_psel & i_penable;
        apb_ofs   = i_paddr - OFS_PRESET_BEG;
        apb_idx   = apb_ofs[MEM_AW+1:2];
        in_mem    = (i_paddr >= OFS_PRESET_BEG) && (i_paddr < OFS_PRESET_END)
                    && (i_paddr[1:0] == 2'b00);
        apb_steal = apb_acc & in_mem & ~i_pwrite & ~st_reg.pready;
        mem_we    = apb_acc & st_reg.pready & i_pwrite & in_mem;
        // Command 4 widens the binary index to presets 9-16
        sel_idx   = {1'b0, ms4, ms3, ms2, ms1};
        // Second jog outranks jog, which outranks the step index
        if (jog2) begin
            sel_idx = MEM_JOG2;
        end else if (jog) begin
            sel_idx = MEM_JOG;
        end
        mem_raddr = apb_steal ? apb_idx : sel_idx;
        mapped    = 1'b1;
        rd_mux    = '0;
        // Fields read back at their register bit positions; unused bits read zero
        case (i_paddr)
            OFS_CTRL: begin
                rd_mux[CTRL_SRC_LSB +: CTRL_SRC_W] = st_reg.src;
                rd_mux[CTRL_SWAP_BIT]              = st_reg.swap;
                rd_mux[CTRL_AIN2F_LSB +: FUNC_W]   = st_reg.ain2f;
                rd_mux[CTRL_PULSEF_LSB +: FUNC_W]  = st_reg.pulsef;
                rd_mux[CTRL_WIRE3_BIT]             = st_reg.wire3;
            end
            OFS_SCALE: begin
                rd_mux[REF_W-1:0] = st_reg.scale;
            end
            OFS_DINF_A: begin
                rd_mux = st_reg.dinf[DATA_W-1:0];
            end
            OFS_DINF_B: begin
                rd_mux[FUNC_W-1:0] = st_reg.dinf[NUM_DIN*FUNC_W-1:DATA_W];
            end
            OFS_STATUS: begin
                rd_mux[REF_W-1:0]                      = st_reg.fref;
                rd_mux[STAT_STEP_LSB +: MEM_AW]        = st_reg.step;
                rd_mux[STAT_ALARM_BIT]                 = st_reg.alarm;
                rd_mux[STAT_DIN_LSB +: NUM_DIN]        = st_reg.din;
            end
            OFS_PULSE: begin
                rd_mux[REF_W-1:0]              = pulse_freq;
                rd_mux[PULSE_REF_LSB +: REF_W] = pulse_ref;
            end
            default: begin
                if (in_mem) begin
                    rd_mux[REF_W-1:0] = mem_rdata;
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_next = st_reg;

        // Terminal filter: a change counts once two late stages agree
        st_next.s1 = i_din;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int k = 0; k < NUM_DIN; k++) begin
            if (st_reg.s2[k] == st_reg.s3[k]) begin
                st_next.din[k] = st_reg.s3[k];
            end
        end

        // Every transfer waits one cycle; preset reads wait two for the RAM
        st_next.pready  = 1'b0;
        st_next.pslverr = 1'b0;
        if (apb_acc && !st_reg.pready) begin
            if (apb_steal && !st_reg.mem_wait) begin
                st_next.mem_wait = 1'b1;
            end else begin
                st_next.mem_wait = 1'b0;
                st_next.pready   = 1'b1;
                st_next.pslverr  = ~mapped;
                st_next.prdata   = i_pwrite ? '0 : rd_mux;
            end
        end
        // A write lands on the edge where the master sees pready
        if (apb_acc && st_reg.pready && i_pwrite) begin
            case (i_paddr)
                OFS_CTRL: begin
                    st_next.src    = i_pwdata[CTRL_SRC_LSB +: CTRL_SRC_W];
                    st_next.swap   = i_pwdata[CTRL_SWAP_BIT];
                    st_next.ain2f  = i_pwdata[CTRL_AIN2F_LSB +: FUNC_W];
                    st_next.pulsef = i_pwdata[CTRL_PULSEF_LSB +: FUNC_W];
                    st_next.wire3  = i_pwdata[CTRL_WIRE3_BIT];
                end
                OFS_SCALE: begin
                    st_next.scale = i_pwdata[REF_W-1:0];
                end
                OFS_DINF_A: begin
                    st_next.dinf[DATA_W-1:0] = i_pwdata;
                end
                OFS_DINF_B: begin
                    st_next.dinf[NUM_DIN*FUNC_W-1:DATA_W] = i_pwdata[FUNC_W-1:0];
                end
                default: begin
                end
            endcase
        end

        // Stage 1: choose the reference kind; a stolen RAM cycle skips it
        st_next.sel_valid = ~apb_steal;
        st_next.use_mem   = 1'b1;
        st_next.value     = '0;
        st_next.step_p    = sel_idx + 5'h01;
        if (jog2) begin
            st_next.step_p = STEP_JOG;
        end else if (jog) begin
            st_next.step_p = STEP_JOG;
        end else if (!ms4 && !ms3 && !ms2 && !ms1) begin
            case (st_reg.src)
                SRC_ANALOG: begin
                    st_next.use_mem = 1'b0;
                    st_next.value   = master_ain;
                end
                SRC_PULSE: begin
                    if (st_reg.pulsef == PULSE_FN_REF) begin
                        st_next.use_mem = 1'b0;
                        st_next.value   = pulse_ref;
                    end
                end
                default: begin
                    // Keypad entry lands in preset 1
                    // Unlisted selector codes fall back to the same word
                    st_next.use_mem = 1'b1;
                end
            endcase
        end else if (ms1 && !ms2 && !ms3 && !ms4 && aux_en) begin
            st_next.use_mem = 1'b0;
            st_next.value   = aux_ain;
        end

        // Stage 2: RAM data is valid one cycle after its address
        if (st_reg.sel_valid) begin
            st_next.fref = st_reg.use_mem ? mem_rdata : st_reg.value;
            st_next.step = st_reg.step_p;
        end

        // Live level: it clears as soon as the setting becomes legal
        st_next.alarm = jog2_assigned & ~st_reg.wire3;
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // Preset RAM keeps no reset; software loads it before use
            st_reg        <= '0;
            st_reg.src    <= SRC_RST;
            st_reg.ain2f  <= AIN2F_RST;
            st_reg.pulsef <= PULSEF_RST;
            st_reg.scale  <= SCALE_RST;
            st_reg.dinf   <= DINF_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////
    frs_ref_mem #(
        .WORDS (MEM_WORDS),
        .W     (REF_W),
        .AW    (MEM_AW)
    ) u_mem (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_we    (mem_we),
        .i_waddr (apb_idx),
        .i_wdata (i_pwdata[REF_W-1:0]),
        .i_raddr (mem_raddr),
        .o_rdata (mem_rdata)
    );

    // Measurement runs free; stage 1 reads its latest result live
    frs_pulse_meas #(
        .GATE_CYCLES (GATE_CYCLES)
    ) u_pulse (
        .i_clk            (i_clk),
        .i_rst_n          (i_rst_n),
        .i_pulse_train_in (i_pulse_train_in),
        .i_scaling        (st_reg.scale),
        .o_freq           (pulse_freq),
        .o_ref            (pulse_ref)
    );

    assign o_prdata              = st_reg.prdata;
    assign o_pready              = st_reg.pready;
    assign o_pslverr             = st_reg.pslverr;
    assign o_freq_ref            = st_reg.fref;
    assign o_ref_step            = st_reg.step;
    assign o_param_setting_alarm = st_reg.alarm;
endmodule
`default_nettype wire

// File: frs_ref_select_properties.sv
`timescale 1ns/1ps
`default_nettype none
module frs_ref_select_properties (
    input wire logic                        i_clk,
    input wire logic                        i_rst_n,
    input wire logic                        i_psel,
    input wire logic                        i_penable,
    input wire logic                        i_pwrite,
    input wire logic [frs_pkg::ADDR_W-1:0]  i_paddr,
    input wire logic [frs_pkg::NUM_DIN-1:0] i_din,
    input wire logic [frs_pkg::DATA_W-1:0]  o_prdata,
    input wire logic                        o_pready,
    input wire logic                        o_pslverr,
    input wire logic [frs_pkg::MEM_AW-1:0]  o_ref_step,
    input wire logic                        o_param_setting_alarm
);
    import frs_pkg::*;
    logic [NUM_DIN-1:0] din_q;
    logic [3:0]         quiet;
    // Counts cycles with no terminal change and no bus traffic
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            din_q <= '0;
            quiet <= '0;
        end else begin
            din_q <= i_din;
            if (i_din != din_q || i_psel) quiet <= '0;
            else if (quiet != 4'hF) quiet <= quiet + 4'h1;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    chk_pready_once:
        assert property (o_pready |=> !o_pready) else $error("pready held too long");
    chk_pready_wait:
        assert property (i_psel && !i_penable |=> !o_pready ##[1:2] o_pready)
            else $error("pready latency wrong");
    chk_err_pair:
        assert property (o_pslverr |-> o_pready) else $error("pslverr without pready");
    chk_err_zero:
        assert property (o_pslverr && !i_pwrite |-> o_prdata == '0) else $error("error data");
    chk_preset_ok:
        assert property (o_pready && i_paddr >= OFS_PRESET_BEG && i_paddr < OFS_PRESET_END
            && i_paddr[1:0] == 2'b00 |-> !o_pslverr) else $error("preset refused");
    chk_step_range:
        assert property (o_ref_step != '0 |-> o_ref_step <= 5'h11) else $error("step range");
    chk_step_hold:
        assert property (quiet >= 4'hA |-> $stable(o_ref_step)) else $error("step moved");
    chk_alarm_cause:
        assert property ($changed(o_param_setting_alarm) |-> $past(o_pready && i_pwrite, 1)
            || $past(o_pready && i_pwrite, 2)) else $error("alarm moved alone");
endmodule
bind frs_ref_select frs_ref_select_properties frs_ref_select_properties_i (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_din(i_din), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .o_ref_step(o_ref_step),
    .o_param_setting_alarm(o_param_setting_alarm));
`default_nettype wire

// File: frs_din_driver.sv
`timescale 1ns/1ps
`default_nettype none
module frs_din_driver #(
    parameter int HALF = 5
) (
    input  wire logic       i_clk,
    input  wire logic [4:0] i_level,
    input  wire logic       i_pulse_en,
    output logic      [4:0] o_din,
    output logic            o_pulse
);
    logic [4:0] din_r = '0;
    logic [7:0] cnt   = '0;
    // Levels change only on a new command and are held meanwhile
    always @(posedge i_clk) begin
        din_r <= i_level;
        cnt   <= (cnt == 8'(2 * HALF - 1)) ? 8'h00 : cnt + 8'h01;
    end
    assign o_din   = din_r;
    assign o_pulse = i_pulse_en && (cnt < 8'(HALF));
endmodule
`default_nettype wire

// File: frs_ref_select_tb.sv
`timescale 1ns/1ps
`default_nettype none
module frs_ref_select_tb;
    import frs_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pulse_en = 0;
    logic [7:0]  paddr = '0;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, pulse, alarm;
    logic [4:0]  level = '0, din, step, exp_step;
    logic [15:0] ain1 = '0, ain2 = '0, freq_ref, preset [0:17];
    int          mismatches = 0, samples_checked = 0;
    int unsigned seed;
    initial forever #50 clk = ~clk;
    frs_ref_select #(.GATE_CYCLES(200)) frs_ref_select_i (.i_clk(clk), .i_rst_n(rst_n),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_din(din), .i_analog_in_first(ain1), .i_analog_in_second(ain2),
        .i_pulse_train_in(pulse), .o_freq_ref(freq_ref), .o_ref_step(step),
        .o_param_setting_alarm(alarm));
    frs_din_driver #(.HALF(5)) frs_din_driver_i (.i_clk(clk), .i_level(level),
        .i_pulse_en(pulse_en), .o_din(din), .o_pulse(pulse));
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (n >= 20) begin
            mismatches++;
            tally_and_finish();
        end
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] r;
        logic e;
        apb(0, a, 32'h0, r, e);
        chk("prdata", x, r);
        chk("pslverr", 32'(xe), 32'(e));
    endtask
    // Terminal map in use: din3 ms4, din4 ms3, din5 ms1, din6 ms2, din7 jog
    function automatic logic [4:0] idx(input logic [4:0] lv);
        return lv[4] ? 5'h10 : {1'b0, lv[0], lv[1], lv[3], lv[2]};
    endfunction
    task automatic sel(input logic [4:0] lv, input logic [15:0] f, input logic [4:0] s);
        level <= lv;
        repeat (12) @(posedge clk);
        chk("freq_ref", 32'(f), 32'(freq_ref));
        chk("step", 32'(s), 32'(step));
    endtask
    initial begin
        seed = $urandom(32'h4a05_98c9);
        repeat (20) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd(OFS_CTRL, 32'h0000_0001, 0);
        rd(OFS_SCALE, 32'h0000_05A0, 0);
        rd(OFS_DINF_A, 32'h0403_050F, 0);
        rd(OFS_DINF_B, 32'h0000_0006, 0);
        rd(8'h20, 32'h0000_0000, 1);
        for (int i = 0; i < 18; i++) begin
            preset[i] = 16'($urandom);
            wr(OFS_PRESET_BEG + 8'(4 * i), {16'h0000, preset[i]});
        end
        rd(OFS_PRESET_BEG + 8'h08, {16'h0000, preset[2]}, 0);
        wr(OFS_DINF_A, 32'h0403_0520);
        wr(OFS_CTRL, 32'h0000_0000);
        for (int i = 0; i < 32; i++) begin
            exp_step = (i >= 16) ? 5'h11 : idx(5'(i)) + 5'h01;
            sel(5'(i), preset[idx(5'(i))], exp_step);
        end
        ain1 <= 16'($urandom);
        ain2 <= 16'($urandom);
        wr(OFS_CTRL, 32'h0000_0201);
        sel(5'h00, ain1, 5'h01);
        sel(5'h04, ain2, 5'h02);
        wr(OFS_CTRL, 32'h0000_0211);
        sel(5'h00, ain2, 5'h01);
        sel(5'h04, ain1, 5'h02);
        wr(OFS_CTRL, 32'h0000_0001);
        sel(5'h04, preset[1], 5'h02);
        pulse_en <= 1;
        wr(OFS_SCALE, 32'h0000_0014);
        wr(OFS_CTRL, 32'h0000_0004);
        repeat (450) @(posedge clk);
        sel(5'h00, 16'h2710, 5'h01);
        rd(OFS_PULSE, {REF_FULL, 16'h0014}, 0);
        wr(OFS_CTRL, 32'h0001_0004);
        sel(5'h00, preset[0], 5'h01);
        wr(OFS_DINF_B, 32'h0000_0045);
        repeat (3) @(posedge clk);
        chk("alarm", 32'h1, 32'(alarm));
        wr(OFS_CTRL, 32'h0100_0000);
        repeat (3) @(posedge clk);
        chk("alarm", 32'h0, 32'(alarm));
        sel(5'h10, preset[17], 5'h11);
        tally_and_finish();
    end
endmodule
`default_nettype wire
